// >>> common/ccec_pkg.sv
// constants and types of the core enhancement control block
//
// What this block does
// [R1] instruction bus cycle takes four clocks
// [R2] unstretched external data move takes two cycles
// [R3] stretch count in control register bits 2:0
// [R4] stretch N adds exactly N instruction cycles
// [R5] stretch count rewritable anytime, applies next move
// [R6] stretch resets to one, three-cycle moves
// [R7] fetch slots are dropped while a move is busy, so stretch delays fetches
// [R8] first pointer at 82h low, 83h high
// [R9] second pointer at 84h low, 85h high
// [R10] select bit picks first or second pointer
// [R11] select is bit 0 of 86h only
// [R12] increment of select register toggles pointer
// [R13] timers reset to twelve clocks per tick
// [R14] rate bit 1 four clocks, 0 twelve
// [R15] bits 5,4,3 set timers 2,1,0
// [R16] stretch applies to reads and writes alike
package ccec_pkg;

  // ---------------------------------------------------------------
  // special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA_POINTER_A_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_A_HIGH = 8'h83;
  localparam logic [7:0] ADDR_DATA_POINTER_B_LOW = 8'h84;
  localparam logic [7:0] ADDR_DATA_POINTER_B_HIGH = 8'h85;
  localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
  localparam logic [7:0] ADDR_CORE_CLOCK_CONTROL = 8'h8E;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_MSB = 2;
  localparam int TIMER0_RATE_BIT = 3;
  localparam int TIMER1_RATE_BIT = 4;
  localparam int TIMER2_RATE_BIT = 5;
  localparam int SELECT_BIT = 0;
  localparam logic [7:0] CORE_CLOCK_CONTROL_RST = 8'h01;
  localparam logic [7:0] POINTER_SELECT_RST = 8'h00;
  localparam logic [7:0] DATA_POINTER_RST = 8'h00;

  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam int CLKS_PER_INSTR_CYCLE = 4;
  localparam int CLKS_PER_FAST_TICK = 4;
  localparam int CLKS_PER_SLOW_TICK = 12;
  localparam int MOVE_BASE_CYCLES = 2;
  localparam logic [3:0] MOVE_BASE_CYCLES_4 = 4'h2;

  // ---------------------------------------------------------------
  // external data move sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CCEC_IDLE = 3'b001,
    CCEC_BUSY = 3'b010,
    CCEC_DONE = 3'b100
  } ccec_move_e;

endpackage

// >>> verilog/ccec_tick_gen.sv
// one timer tick generator, four or twelve clocks per tick
`timescale 1ns/1ps
module ccec_tick_gen #(
  parameter int FAST_DIV = ccec_pkg::CLKS_PER_FAST_TICK,
  parameter int SLOW_DIV = ccec_pkg::CLKS_PER_SLOW_TICK
) (
  input wire logic clk_sys, // core clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic fast_sel, // 1 selects fast divider
  output logic tick // one-cycle tick pulse
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] last;
  logic wrap;

  assign last = fast_sel ? 4'(FAST_DIV - 1) : 4'(SLOW_DIV - 1); // R14
  assign wrap = (cnt_r >= last);
  assign cnt_nxt = wrap ? 4'h0 : cnt_r + 4'h1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= wrap;
    end
  end

  property p_tick_spacing;
    @(posedge clk_sys) disable iff (!rst_n)
      ($rose(tick) && fast_sel) ##1 (fast_sel && !tick) [*3] |=> tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("fast tick spacing not four clocks"); // R14

endmodule // ccec_tick_gen

// >>> verilog/ccec_core_ctrl.sv
// core enhancement control: sfr file, dual pointers, move stretch, timer rates
`timescale 1ns/1ps
module ccec_core_ctrl (
  input wire logic clk_sys, // core clock, 10 MHz
  input wire logic rstn, // chip reset, active low
  input wire logic [7:0] sfr_addr, // special function register address
  input wire logic sfr_wr, // write strobe
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic sfr_rd, // read strobe
  input wire logic ptr_inc, // increment active pointer
  input wire logic sel_inc, // increment applied to pointer select
  input wire logic move_start, // external data move begins
  input wire logic move_write, // 1 write, 0 read
  output logic [7:0] sfr_rdata, // read data
  output logic sfr_hit, // address belongs to this block
  output logic [15:0] active_ptr, // currently selected pointer
  output logic move_rd_strobe, // external read strobe
  output logic move_wr_strobe, // external write strobe
  output logic move_busy, // external data move in progress
  output logic move_done, // move completes, one pulse
  output logic instr_phase_end, // high the clock after the last clock of an instruction cycle
  output logic fetch_slot, // program fetch slot, dropped while move_busy
  output logic timer0_tick, // timer 0 count tick
  output logic timer1_tick, // timer 1 count tick
  output logic timer2_tick // timer 2 count tick
);

  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic [7:0] core_clock_control_r;
  logic [7:0] pointer_select_r;
  logic [15:0] primary_data_pointer_r;
  logic [15:0] secondary_data_pointer_r;
  logic [7:0] core_clock_control_nxt;
  logic [7:0] pointer_select_nxt;
  logic [15:0] primary_data_pointer_nxt;
  logic [15:0] secondary_data_pointer_nxt;

  wire hit_a_lo = (sfr_addr == ccec_pkg::ADDR_DATA_POINTER_A_LOW); // R8
  wire hit_a_hi = (sfr_addr == ccec_pkg::ADDR_DATA_POINTER_A_HIGH); // R8
  wire hit_b_lo = (sfr_addr == ccec_pkg::ADDR_DATA_POINTER_B_LOW); // R9
  wire hit_b_hi = (sfr_addr == ccec_pkg::ADDR_DATA_POINTER_B_HIGH); // R9
  wire hit_sel = (sfr_addr == ccec_pkg::ADDR_POINTER_SELECT); // R11
  wire hit_ccc = (sfr_addr == ccec_pkg::ADDR_CORE_CLOCK_CONTROL); // R3
  wire any_hit = hit_a_lo | hit_a_hi | hit_b_lo | hit_b_hi | hit_sel | hit_ccc;
  wire sel_b = pointer_select_r[ccec_pkg::SELECT_BIT]; // R10
  wire inc_a = ptr_inc & ~sel_b; // R10
  wire inc_b = ptr_inc & sel_b; // R10
  wire [15:0] ptr_a_inc = primary_data_pointer_r + 16'h0001;
  wire [15:0] ptr_b_inc = secondary_data_pointer_r + 16'h0001;

  // register writes take priority over pointer increments in the same cycle
  assign primary_data_pointer_nxt = {
    (sfr_wr & hit_a_hi) ? sfr_wdata : (inc_a ? ptr_a_inc[15:8] : primary_data_pointer_r[15:8]),
    (sfr_wr & hit_a_lo) ? sfr_wdata : (inc_a ? ptr_a_inc[7:0] : primary_data_pointer_r[7:0])
  }; // R8
  assign secondary_data_pointer_nxt = {
    (sfr_wr & hit_b_hi) ? sfr_wdata : (inc_b ? ptr_b_inc[15:8] : secondary_data_pointer_r[15:8]),
    (sfr_wr & hit_b_lo) ? sfr_wdata : (inc_b ? ptr_b_inc[7:0] : secondary_data_pointer_r[7:0])
  }; // R9
  // only the select bit is stored; increment flips it
  assign pointer_select_nxt = (sfr_wr & hit_sel) ? {7'h00, sfr_wdata[ccec_pkg::SELECT_BIT]} :
                              sel_inc ? {7'h00, ~sel_b} : pointer_select_r; // R11 R12
  assign core_clock_control_nxt = (sfr_wr & hit_ccc) ? {2'b00, sfr_wdata[5:0]} :
                                  core_clock_control_r; // R5 R15

  wire [7:0] rdata_nxt = hit_a_lo ? primary_data_pointer_r[7:0] :
                         hit_a_hi ? primary_data_pointer_r[15:8] :
                         hit_b_lo ? secondary_data_pointer_r[7:0] :
                         hit_b_hi ? secondary_data_pointer_r[15:8] :
                         hit_sel ? pointer_select_r :
                         hit_ccc ? core_clock_control_r : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      core_clock_control_r <= ccec_pkg::CORE_CLOCK_CONTROL_RST; // R6 R13
      pointer_select_r <= ccec_pkg::POINTER_SELECT_RST;
      primary_data_pointer_r <= {ccec_pkg::DATA_POINTER_RST, ccec_pkg::DATA_POINTER_RST};
      secondary_data_pointer_r <= {ccec_pkg::DATA_POINTER_RST, ccec_pkg::DATA_POINTER_RST};
    end else begin
      core_clock_control_r <= core_clock_control_nxt;
      pointer_select_r <= pointer_select_nxt;
      primary_data_pointer_r <= primary_data_pointer_nxt;
      secondary_data_pointer_r <= secondary_data_pointer_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
      active_ptr <= 16'h0000;
    end else begin
      sfr_rdata <= sfr_rd ? rdata_nxt : 8'h00;
      sfr_hit <= (sfr_rd | sfr_wr) & any_hit;
      active_ptr <= pointer_select_nxt[ccec_pkg::SELECT_BIT] ? secondary_data_pointer_nxt :
                    primary_data_pointer_nxt; // R10
    end
  end

  // ---------------------------------------------------------------
  // instruction cycle phase
  // ---------------------------------------------------------------
  logic [1:0] phase_r;
  wire phase_last = (phase_r == 2'(ccec_pkg::CLKS_PER_INSTR_CYCLE - 1)); // R1
  wire [1:0] phase_nxt = phase_last ? 2'h0 : phase_r + 2'h1;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      phase_r <= 2'h0;
      instr_phase_end <= 1'b0;
      fetch_slot <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      instr_phase_end <= phase_last; // R1
      // fetch pacing depends on the phase and on move_busy, so a stretched move delays fetches
      fetch_slot <= phase_last & ~move_busy; // R7
    end
  end

  // ---------------------------------------------------------------
  // external data move sequencer
  // ---------------------------------------------------------------
  ccec_pkg::ccec_move_e move_st_r;
  ccec_pkg::ccec_move_e move_st_nxt;
  logic [3:0] cyc_left_r;
  logic [3:0] cyc_left_nxt;
  logic dir_wr_r;

  // the count is sampled at the start, so a rewrite affects only later moves
  wire [3:0] move_len = ccec_pkg::MOVE_BASE_CYCLES_4 +
                        {1'b0, core_clock_control_r[ccec_pkg::STRETCH_MSB:ccec_pkg::STRETCH_LSB]}; // R2 R3 R4 R5
  wire start_ok = move_start & (move_st_r == ccec_pkg::CCEC_IDLE);

  always_comb begin
    move_st_nxt = move_st_r;
    cyc_left_nxt = cyc_left_r;
    unique case (move_st_r)
      ccec_pkg::CCEC_IDLE: begin
        if (start_ok) begin
          move_st_nxt = ccec_pkg::CCEC_BUSY;
          cyc_left_nxt = move_len; // R4
        end
      end
      ccec_pkg::CCEC_BUSY: begin
        if (phase_last) begin
          cyc_left_nxt = cyc_left_r - 4'h1;
          if (cyc_left_r == 4'h1) begin
            move_st_nxt = ccec_pkg::CCEC_DONE;
          end
        end
      end
      ccec_pkg::CCEC_DONE: begin
        move_st_nxt = ccec_pkg::CCEC_IDLE;
      end
      default: begin
        move_st_nxt = ccec_pkg::CCEC_IDLE;
        cyc_left_nxt = 4'h0;
      end
    endcase
  end

  wire busy_nxt = (move_st_nxt == ccec_pkg::CCEC_BUSY);

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      move_st_r <= ccec_pkg::CCEC_IDLE;
      cyc_left_r <= 4'h0;
      dir_wr_r <= 1'b0;
      move_busy <= 1'b0;
      move_done <= 1'b0;
      move_rd_strobe <= 1'b0;
      move_wr_strobe <= 1'b0;
    end else begin
      move_st_r <= move_st_nxt;
      cyc_left_r <= cyc_left_nxt;
      dir_wr_r <= start_ok ? move_write : dir_wr_r;
      move_busy <= busy_nxt;
      move_done <= (move_st_nxt == ccec_pkg::CCEC_DONE);
      // strobes held across every added cycle, reads and writes alike
      move_rd_strobe <= busy_nxt & ~(start_ok ? move_write : dir_wr_r); // R16
      move_wr_strobe <= busy_nxt & (start_ok ? move_write : dir_wr_r); // R16
    end
  end

  // ---------------------------------------------------------------
  // timer tick generators
  // ---------------------------------------------------------------
  ccec_tick_gen u_tick0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n_r),
    .fast_sel(core_clock_control_r[ccec_pkg::TIMER0_RATE_BIT]), // R15
    .tick(timer0_tick)
  );

  ccec_tick_gen u_tick1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n_r),
    .fast_sel(core_clock_control_r[ccec_pkg::TIMER1_RATE_BIT]), // R15
    .tick(timer1_tick)
  );

  ccec_tick_gen u_tick2 (
    .clk_sys(clk_sys),
    .rst_n(rst_n_r),
    .fast_sel(core_clock_control_r[ccec_pkg::TIMER2_RATE_BIT]), // R15
    .tick(timer2_tick)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_phase_period;
    @(posedge clk_sys) disable iff (!rst_n_r)
      instr_phase_end |=> !instr_phase_end [*3] ##1 instr_phase_end;
  endproperty
  a_phase_period: assert property (p_phase_period) else $error("instruction cycle not four clocks"); // R1

  property p_base_move;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (start_ok && core_clock_control_r[2:0] == 3'h0 && phase_last) |=> move_busy [*8] ##1 move_done;
  endproperty
  a_base_move: assert property (p_base_move) else $error("unstretched move not two cycles"); // R2

  property p_len_load;
    @(posedge clk_sys) disable iff (!rst_n_r)
      start_ok |=> cyc_left_r == 4'h2 + {1'b0, $past(core_clock_control_r[2:0])};
  endproperty
  a_len_load: assert property (p_len_load) else $error("move length not two plus stretch"); // R3

  property p_max_move;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (start_ok && core_clock_control_r[2:0] == 3'h7) |-> ##[34:37] move_done;
  endproperty
  a_max_move: assert property (p_max_move) else $error("stretch seven not nine cycles"); // R4

  property p_len_stable;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (move_st_r == ccec_pkg::CCEC_BUSY && !phase_last) |=> $stable(cyc_left_r);
  endproperty
  a_len_stable: assert property (p_len_stable) else $error("move count changed mid cycle"); // R5

  property p_reset_stretch;
    @(posedge clk_sys) $rose(rst_n_r) |-> core_clock_control_r == 8'h01;
  endproperty
  a_reset_stretch: assert property (p_reset_stretch) else $error("control register reset not 01"); // R6 R13

  property p_fetch_free;
    @(posedge clk_sys) disable iff (!rst_n_r)
      fetch_slot |-> instr_phase_end;
  endproperty
  a_fetch_free: assert property (p_fetch_free) else $error("fetch slot off phase"); // R7

  property p_active_sel;
    @(posedge clk_sys) disable iff (!rst_n_r)
      ##1 active_ptr == (sel_b ? secondary_data_pointer_r : primary_data_pointer_r);
  endproperty
  a_active_sel: assert property (p_active_sel) else $error("active pointer mismatch"); // R8 R9 R10

  property p_sel_bits;
    @(posedge clk_sys) disable iff (!rst_n_r)
      pointer_select_r[7:1] == 7'h00;
  endproperty
  a_sel_bits: assert property (p_sel_bits) else $error("unused select bits set"); // R11

  property p_sel_toggle;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (sel_inc && !(sfr_wr && hit_sel)) |=> sel_b != $past(sel_b);
  endproperty
  a_sel_toggle: assert property (p_sel_toggle) else $error("increment did not toggle select"); // R12

  property p_strobe_hold;
    @(posedge clk_sys) disable iff (!rst_n_r)
      move_busy |-> (move_rd_strobe ^ move_wr_strobe);
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe dropped during move"); // R16

  property p_ccc_write;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (sfr_wr && hit_ccc) |=> core_clock_control_r[2:0] == $past(sfr_wdata[2:0]);
  endproperty
  a_ccc_write: assert property (p_ccc_write) else $error("stretch count write lost"); // R3 R5

  property p_rate_write;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (sfr_wr && hit_ccc) |=> core_clock_control_r[5:3] == $past(sfr_wdata[5:3]);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("timer rate write lost"); // R15

  property p_sel_write;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (sfr_wr && hit_sel) |=> pointer_select_r == {7'h00, $past(sfr_wdata[0])};
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write not bit 0 only"); // R11

  property p_inc_a;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (ptr_inc && !sel_b && !(sfr_wr && (hit_a_lo || hit_a_hi))) |=>
        primary_data_pointer_r == $past(primary_data_pointer_r) + 16'h0001;
  endproperty
  a_inc_a: assert property (p_inc_a) else $error("first pointer not incremented"); // R10

  property p_inc_b;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (ptr_inc && sel_b && !(sfr_wr && (hit_b_lo || hit_b_hi))) |=>
        secondary_data_pointer_r == $past(secondary_data_pointer_r) + 16'h0001;
  endproperty
  a_inc_b: assert property (p_inc_b) else $error("second pointer not incremented"); // R10

  property p_start_busy;
    @(posedge clk_sys) disable iff (!rst_n_r)
      start_ok |=> move_busy && !move_done;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("move did not start"); // R2

  property p_done_pulse;
    @(posedge clk_sys) disable iff (!rst_n_r)
      move_done |=> !move_done && !move_busy;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("move done not one pulse"); // R2

  property p_ignore_start;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (move_start && move_busy) |=> move_busy || move_done;
  endproperty
  a_ignore_start: assert property (p_ignore_start) else $error("start during move disturbed it"); // R4

  property p_strobe_busy;
    @(posedge clk_sys) disable iff (!rst_n_r)
      (move_rd_strobe || move_wr_strobe) |-> move_busy;
  endproperty
  a_strobe_busy: assert property (p_strobe_busy) else $error("strobe outside move"); // R16

  property p_strobe_dir;
    @(posedge clk_sys) disable iff (!rst_n_r)
      start_ok |=> move_wr_strobe == $past(move_write);
  endproperty
  a_strobe_dir: assert property (p_strobe_dir) else $error("strobe kind not move direction"); // R16

endmodule // ccec_core_ctrl

// >>> verif/ccec_xmem_model.sv
// stand-in for slow external data memory, measures each access strobe
`timescale 1ns/1ps
module ccec_xmem_model (
  input wire logic clk_sys, // core clock
  input wire logic move_rd_strobe, // read strobe from block
  input wire logic move_wr_strobe, // write strobe from block
  output int last_len, // cycles the last strobe stood
  output logic last_write // 1 when last access was a write
);
  int run = 0;
  initial last_len = 0;
  initial last_write = 1'b0;
  always @(posedge clk_sys) begin
    if (move_rd_strobe === 1'b1 || move_wr_strobe === 1'b1) begin
      run <= run + 1;
      last_write <= move_wr_strobe;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
  end
endmodule // ccec_xmem_model

// >>> verif/testbench.sv
// self-checking bench for the core enhancement control block
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata; logic hit;} ccec_row_s;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic ptr_inc = 1'b0;
  logic sel_inc = 1'b0;
  logic move_start = 1'b0;
  logic move_write = 1'b0;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic [15:0] active_ptr;
  logic move_rd_strobe, move_wr_strobe, move_busy, move_done;
  logic instr_phase_end, fetch_slot, timer0_tick, timer1_tick, timer2_tick;
  int last_len;
  logic last_write;
  int n_errors = 0;
  int tests_run = 0;
  ccec_row_s rows [8] = '{'{8'h82, 8'hA5, 8'hA5, 1'b1}, '{8'h83, 8'h5A, 8'h5A, 1'b1},
    '{8'h84, 8'h3C, 8'h3C, 1'b1}, '{8'h85, 8'hC3, 8'hC3, 1'b1}, '{8'h86, 8'hFF, 8'h01, 1'b1},
    '{8'h8E, 8'hFF, 8'h3F, 1'b1}, '{8'h8E, 8'h00, 8'h00, 1'b1}, '{8'h90, 8'h77, 8'h00, 1'b0}};
  logic [7:0] regs [6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8E};
  logic [7:0] rates [6] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h38, 8'h07};

  always #50 clk_sys = ~clk_sys;

  ccec_core_ctrl ccec_core_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .ptr_inc(ptr_inc), .sel_inc(sel_inc), .move_start(move_start),
    .move_write(move_write), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .active_ptr(active_ptr),
    .move_rd_strobe(move_rd_strobe), .move_wr_strobe(move_wr_strobe), .move_busy(move_busy),
    .move_done(move_done), .instr_phase_end(instr_phase_end), .fetch_slot(fetch_slot),
    .timer0_tick(timer0_tick), .timer1_tick(timer1_tick), .timer2_tick(timer2_tick));

  ccec_xmem_model ccec_xmem_model_i (.clk_sys(clk_sys), .move_rd_strobe(move_rd_strobe),
    .move_wr_strobe(move_wr_strobe), .last_len(last_len), .last_write(last_write));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    check({8'h00, sfr_rdata}, {8'h00, exp});
    check({15'h0000, sfr_hit}, {15'h0000, hit});
    cyc(1);
  endtask

  // counts pulses over 48 clocks, a whole number of 4- and 12-clock periods
  task automatic check_counts(input logic [7:0] r);
    int c [5];
    c = '{default: 0};
    cyc(12);
    repeat (48) begin
      cyc(1);
      c[0] += int'(instr_phase_end === 1'b1);
      c[1] += int'(fetch_slot === 1'b1);
      c[2] += int'(timer0_tick === 1'b1);
      c[3] += int'(timer1_tick === 1'b1);
      c[4] += int'(timer2_tick === 1'b1);
    end
    check(16'(c[0]), 16'h000C);
    check(16'(c[1]), 16'h000C);
    check(16'(c[2]), r[3] ? 16'h000C : 16'h0004);
    check(16'(c[3]), r[4] ? 16'h000C : 16'h0004);
    check(16'(c[4]), r[5] ? 16'h000C : 16'h0004);
  endtask

  // mid: rewrites stretch to 7 and retries start while the move runs
  task automatic do_move(input logic wr, input int n, input logic mid);
    int k;
    int ph;
    int busy;
    k = 0;
    while (instr_phase_end !== 1'b1 && k < 8) begin
      cyc(1);
      k++;
    end
    if (k >= 8) begin
      n_errors++;
      final_report();
    end
    // unstretched move starts on the last clock of a cycle
    if (n == 0) cyc(3);
    move_write = wr;
    move_start = 1'b1;
    k = 0;
    ph = 0;
    busy = 0;
    do begin
      cyc(1);
      if (k == 0) move_start = 1'b0;
      if (mid && k == 2) begin
        sfr_addr = 8'h8E;
        sfr_wdata = 8'h07;
        sfr_wr = 1'b1;
        move_start = 1'b1;
      end
      if (mid && k == 3) begin
        sfr_wr = 1'b0;
        move_start = 1'b0;
      end
      ph += int'(k > 0 && instr_phase_end === 1'b1);
      busy += int'(move_busy === 1'b1);
      k++;
    end while (move_done !== 1'b1 && k < 60);
    if (k >= 60) begin
      n_errors++;
      final_report();
    end
    check(16'(ph), 16'(2 + n));
    check(16'(busy), (n == 0) ? 16'h0008 : 16'(4 * n + 7));
    cyc(2);
    check(16'(last_len), 16'(busy));
    check({15'h0000, last_write}, {15'h0000, wr});
    check({15'h0000, move_busy}, 16'h0000);
  endtask

  task automatic reset_checks;
    rstn = 1'b0;
    cyc(3);
    rstn = 1'b1;
    cyc(3);
    foreach (regs[i]) sfr_read(regs[i], (i == 5) ? 8'h01 : 8'h00, 1'b1);
    check_counts(8'h01);
    do_move(1'b0, 1, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_checks();
    foreach (rows[i]) begin
      sfr_write(rows[i].addr, rows[i].wdata);
      sfr_read(rows[i].addr, rows[i].rdata, rows[i].hit);
    end
    sfr_write(8'h86, 8'h00);
    check(active_ptr, 16'h5AA5);
    sel_inc = 1'b1;
    cyc(1);
    sel_inc = 1'b0;
    cyc(1);
    check(active_ptr, 16'hC33C);
    sfr_read(8'h86, 8'h01, 1'b1);
    ptr_inc = 1'b1;
    cyc(1);
    ptr_inc = 1'b0;
    cyc(1);
    check(active_ptr, 16'hC33D);
    sfr_read(8'h84, 8'h3D, 1'b1);
    sfr_read(8'h82, 8'hA5, 1'b1);
    sel_inc = 1'b1;
    cyc(1);
    sel_inc = 1'b0;
    cyc(1);
    check(active_ptr, 16'h5AA5);
    ptr_inc = 1'b1;
    cyc(1);
    ptr_inc = 1'b0;
    cyc(1);
    check(active_ptr, 16'h5AA6);
    foreach (rates[i]) begin
      sfr_write(8'h8E, rates[i]);
      check_counts(rates[i]);
    end
    for (int n = 0; n < 8; n++) begin
      sfr_write(8'h8E, 8'(n));
      do_move(n[0], n, 1'b0);
    end
    sfr_write(8'h8E, 8'h02);
    do_move(1'b0, 2, 1'b1);
    do_move(1'b1, 7, 1'b0);
    reset_checks();
    final_report();
  end
endmodule // testbench
